// ==== hw/bidirectional_port_pin_control.sv ====
// What this block does
// - After reset every pin is on the latch path with its driver off; router picks others.
// - Analog mode enables analog inputs; digital output may still drive the pin.
// - An enabled analog output wins and turns the digital driver off.
// - Ownership order: configuration, analog out, then port or router.
// - Eight bidirectional pins, one bit each in all seven registers.
// - Direction bit one makes the pin an input, driver disabled.
// - Direction bit zero enables the driver with the latch value.
// - Pin-value read gives pin levels; writing it updates the latch.
// - Port writes replace the whole output latch with the written value.
// - Latch holds the latest write to either latch or pin-value register.
// - Direction bits steer drivers even on analog input pins.
// - Digital reads of analog-selected pins return zero.
// - Analog select leaves digital output unaffected.
// - Analog select resets to analog; software clears it for digital use.
// - Open-drain bit set sinks only; clear drives both levels.
// - Serial two-wire peripheral forces open-drain on pins it owns.
`timescale 1ns/1ps
module bidirectional_port_pin_control (
  input  wire logic                      sys_clk,       // System clock, 40 MHz.
  input  wire logic                      rst_n,         // Asynchronous reset, low.
  input  wire gpio_port_pkg::reg_req_s   reg_req,       // Register bus request.
  output logic    [7:0]                  reg_rdata,     // Read data, cycle after read.
  input  wire gpio_port_pkg::pin_vec_t   pad_in,        // Pin levels from the pads.
  output gpio_port_pkg::pad_drive_s      pad_drive,     // Pad output value and enable.
  output gpio_port_pkg::pin_vec_t        pad_ibuf_en,   // Digital input buffer enable.
  output gpio_port_pkg::pin_vec_t        digital_in,    // Filtered digital pin levels.
  input  wire gpio_port_pkg::pin_vec_t   cfg_own,       // Configuration bits own pin.
  input  wire gpio_port_pkg::pad_drive_s cfg_drive,     // Drive when configuration owns.
  input  wire gpio_port_pkg::pin_vec_t   analog_out_en, // Analog output enabled.
  input  wire gpio_port_pkg::pad_drive_s alt_drive      // Routed peripheral drive.
);
  import gpio_port_pkg::*;

  logic     rst_meta;
  logic     rst_sync_n;
  pin_vec_t pad_meta;
  pin_vec_t pad_sync;
  pin_vec_t direction;
  pin_vec_t latch;
  pin_vec_t analog_sel;
  pin_vec_t open_drain;
  pin_vec_t alt_sel;
  pin_vec_t alt_serial;
  pin_vec_t read_levels;
  wire pin_vec_t next_o;
  wire pin_vec_t next_oe;
  wire pin_vec_t next_ibuf;
  logic [7:0] next_rdata;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Pads are asynchronous; only the second stage feeds logic.
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pad_meta <= ZERO_VEC;
      pad_sync <= ZERO_VEC;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  // Analog pins read as zero so software never sees a floating level.
  assign read_levels = pad_sync & ~analog_sel;

  // Latch takes writes from either register; a port write replaces every bit.
  // No bits are merged; the write data land in the latch as they are.
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      latch <= RESET_LATCH;
    end else if (reg_req.wr) begin
      if (reg_req.addr == ADDR_PIN_VALUE || reg_req.addr == ADDR_LATCH) begin
        latch <= reg_req.wdata;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      direction  <= RESET_DIRECTION;
      analog_sel <= RESET_ANALOG_SEL;
      open_drain <= RESET_OPEN_DRAIN;
      alt_sel    <= RESET_ALT_SEL;
      alt_serial <= RESET_ALT_SERIAL;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_DIRECTION:  direction  <= reg_req.wdata;
        ADDR_ANALOG_SEL: analog_sel <= reg_req.wdata;
        ADDR_OPEN_DRAIN: open_drain <= reg_req.wdata;
        ADDR_ALT_SEL:    alt_sel    <= reg_req.wdata;
        ADDR_ALT_SERIAL: alt_serial <= reg_req.wdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    next_rdata = ZERO_VEC;
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_PIN_VALUE:  next_rdata = read_levels;
        ADDR_DIRECTION:  next_rdata = direction;
        ADDR_LATCH:      next_rdata = latch;
        ADDR_ANALOG_SEL: next_rdata = analog_sel;
        ADDR_OPEN_DRAIN: next_rdata = open_drain;
        ADDR_ALT_SEL:    next_rdata = alt_sel;
        ADDR_ALT_SERIAL: next_rdata = alt_serial;
        default:         next_rdata = ZERO_VEC;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      reg_rdata <= ZERO_VEC;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // Per-pin ownership, highest priority first.
  // Each pin resolves its owner on its own, so a peripheral can take one pin
  // while its neighbours stay on the latch path.
  generate
    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_pin
      logic val;
      logic en;
      logic od;
      logic ibuf;
      always_comb begin
        val  = latch[i];
        en   = ~direction[i];
        od   = open_drain[i];
        ibuf = ~analog_sel[i];
        if (cfg_own[i]) begin
          val  = cfg_drive.o[i];
          en   = cfg_drive.oe[i];
          od   = 1'b0;
          ibuf = 1'b1;
        end else if (analog_out_en[i]) begin
          // The latch value stays on o so that releasing the analog output
          // does not put a stale level on the pin.
          en   = 1'b0;
          od   = 1'b0;
          ibuf = 1'b0;
        end else if (alt_sel[i]) begin
          val = alt_drive.o[i];
          en  = alt_drive.oe[i];
          od  = od | alt_serial[i];
        end
      end
      // Open drain only ever releases the pin for a one, never drives it high.
      assign next_o[i]    = val;
      assign next_oe[i]   = od ? (en & ~val) : en;
      assign next_ibuf[i] = ibuf;
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pad_drive.o  <= RESET_LATCH;
      pad_drive.oe <= ZERO_VEC;
      pad_ibuf_en  <= ZERO_VEC;
      digital_in   <= ZERO_VEC;
    end else begin
      pad_drive.o  <= next_o;
      pad_drive.oe <= next_oe;
      pad_ibuf_en  <= next_ibuf;
      digital_in   <= read_levels;
    end
  end

  // Register-side checks.
  a_analog_read_zero: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.rd && reg_req.addr == ADDR_PIN_VALUE)
    |=> ((reg_rdata & $past(analog_sel)) == ZERO_VEC))
    else $error("analog pin read nonzero");

  a_write_to_latch: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.wr && reg_req.addr == ADDR_PIN_VALUE)
    |=> latch == $past(reg_req.wdata))
    else $error("pin write missed latch");

  a_latch_write: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.wr && reg_req.addr == ADDR_LATCH)
    |=> latch == $past(reg_req.wdata))
    else $error("latch write lost");

  // The latch must not move between writes, or a quiet pin would toggle.
  a_latch_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    !(reg_req.wr && (reg_req.addr == ADDR_PIN_VALUE || reg_req.addr == ADDR_LATCH))
    |=> latch == $past(latch))
    else $error("latch changed without write");

  // Read data stand for one cycle only; otherwise the bus sees zero.
  a_rdata_idle: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    !reg_req.rd
    |=> reg_rdata == ZERO_VEC)
    else $error("read data outside read");

  // A pin-value read returns synchronised levels, not the latch.
  a_pin_read: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.rd && reg_req.addr == ADDR_PIN_VALUE)
    |=> reg_rdata == $past(pad_sync & ~analog_sel))
    else $error("pin read wrong");

  // Direction reads back as written.
  a_dir_read: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.rd && reg_req.addr == ADDR_DIRECTION)
    |=> reg_rdata == $past(direction))
    else $error("direction read wrong");

  // Latch reads give the stored value, not the pin levels.
  a_latch_read: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.rd && reg_req.addr == ADDR_LATCH)
    |=> reg_rdata == $past(latch))
    else $error("latch read wrong");

  // Analog select reads back as stored.
  a_analog_sel_read: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.rd && reg_req.addr == ADDR_ANALOG_SEL)
    |=> reg_rdata == $past(analog_sel))
    else $error("analog select read wrong");

  // Open-drain bits read back as stored.
  a_od_read: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.rd && reg_req.addr == ADDR_OPEN_DRAIN)
    |=> reg_rdata == $past(open_drain))
    else $error("open drain read wrong");

  // A direction write lands on the next edge.
  a_dir_write: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.wr && reg_req.addr == ADDR_DIRECTION)
    |=> direction == $past(reg_req.wdata))
    else $error("direction write lost");

  // Software must be able to clear analog mode.
  a_analog_write: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.wr && reg_req.addr == ADDR_ANALOG_SEL)
    |=> analog_sel == $past(reg_req.wdata))
    else $error("analog select write lost");

  // Open-drain bits are written per pin.
  a_od_write: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (reg_req.wr && reg_req.addr == ADDR_OPEN_DRAIN)
    |=> open_drain == $past(reg_req.wdata))
    else $error("open drain write lost");

  // Pad-side checks.
  a_input_no_drive: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (direction == ~ZERO_VEC && cfg_own == ZERO_VEC && alt_sel == ZERO_VEC)
    |=> pad_drive.oe == ZERO_VEC)
    else $error("input pin driven");

  a_output_drives: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (direction == ZERO_VEC && open_drain == ZERO_VEC && cfg_own == ZERO_VEC
     && analog_out_en == ZERO_VEC && alt_sel == ZERO_VEC)
    |=> (pad_drive.oe == ~ZERO_VEC && pad_drive.o == $past(latch)))
    else $error("output not driving latch");

  // Direction alone steers the driver, analog input mode or not.
  a_dir_on_analog: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (cfg_own == ZERO_VEC && analog_out_en == ZERO_VEC && alt_sel == ZERO_VEC
     && open_drain == ZERO_VEC)
    |=> pad_drive.oe == ~$past(direction))
    else $error("direction ignored");

  // Analog select never changes the value put on the pad.
  a_analog_keeps_out: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (cfg_own == ZERO_VEC && alt_sel == ZERO_VEC)
    |=> pad_drive.o == $past(latch))
    else $error("analog select changed output");

  a_analog_out_hiz: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (analog_out_en != ZERO_VEC && cfg_own == ZERO_VEC)
    |=> (pad_drive.oe & $past(analog_out_en)) == ZERO_VEC)
    else $error("analog output pin still driven");

  // Analog outputs shut the digital input buffers.
  a_analog_out_ibuf: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    1'b1
    |=> (pad_ibuf_en & $past(analog_out_en & ~cfg_own)) == ZERO_VEC)
    else $error("input buffer on under analog output");

  // With no higher owner the input buffer follows analog select.
  a_ibuf_follow: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (cfg_own == ZERO_VEC && analog_out_en == ZERO_VEC)
    |=> pad_ibuf_en == ~$past(analog_sel))
    else $error("input buffer wrong");

  // Filtered levels are masked the same way as register reads.
  a_digital_mask: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    1'b1
    |=> (digital_in & $past(analog_sel)) == ZERO_VEC)
    else $error("analog pin level leaked");

  a_cfg_priority: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (cfg_own == ~ZERO_VEC)
    |=> pad_drive.oe == $past(cfg_drive.oe))
    else $error("configuration lost priority");

  // Configuration owns value and input buffer as well as the enable.
  a_cfg_value: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (cfg_own == ~ZERO_VEC)
    |=> (pad_drive.o == $past(cfg_drive.o) && pad_ibuf_en == ~ZERO_VEC))
    else $error("configuration value lost");

  // A routed peripheral puts its own value on the pad.
  a_alt_value: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    (cfg_own == ZERO_VEC && analog_out_en == ZERO_VEC && alt_sel == ~ZERO_VEC)
    |=> pad_drive.o == $past(alt_drive.o))
    else $error("routed value lost");

  a_open_drain: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    1'b1
    |=> (pad_drive.oe & pad_drive.o & ($past(open_drain) & ~$past(cfg_own))) == ZERO_VEC)
    else $error("open drain drove high");

  a_serial_od: assert property (
    @(posedge sys_clk) disable iff (!rst_sync_n)
    1'b1
    |=> (pad_drive.oe & pad_drive.o & $past(alt_serial & alt_sel & ~cfg_own)) == ZERO_VEC)
    else $error("serial pin drove high");

  // Reset values are checked at the edge where the internal reset lifts.
  a_analog_reset: assert property (
    @(posedge sys_clk)
    $rose(rst_sync_n)
    |-> analog_sel == RESET_ANALOG_SEL)
    else $error("analog select reset wrong");

  // After reset every pin sits on the latch path, no routed owner.
  a_reset_latch_path: assert property (
    @(posedge sys_clk)
    $rose(rst_sync_n)
    |-> (latch == RESET_LATCH && alt_sel == RESET_ALT_SEL))
    else $error("pin not on latch path after reset");
endmodule

// ==== hw/gpio_port_pkg.sv ====
package gpio_port_pkg;

  localparam int PIN_COUNT = 8;

  typedef logic [PIN_COUNT-1:0] pin_vec_t;

  localparam logic [2:0] ADDR_PIN_VALUE  = 3'h0;
  localparam logic [2:0] ADDR_DIRECTION  = 3'h1;
  localparam logic [2:0] ADDR_LATCH      = 3'h2;
  localparam logic [2:0] ADDR_ANALOG_SEL = 3'h3;
  localparam logic [2:0] ADDR_OPEN_DRAIN = 3'h4;
  localparam logic [2:0] ADDR_ALT_SEL    = 3'h5;
  localparam logic [2:0] ADDR_ALT_SERIAL = 3'h6;

  localparam pin_vec_t RESET_DIRECTION  = 8'hff;
  localparam pin_vec_t RESET_LATCH      = 8'h00;
  localparam pin_vec_t RESET_ANALOG_SEL = 8'hff;
  localparam pin_vec_t RESET_OPEN_DRAIN = 8'h00;
  localparam pin_vec_t RESET_ALT_SEL    = 8'h00;
  localparam pin_vec_t RESET_ALT_SERIAL = 8'h00;
  localparam pin_vec_t ZERO_VEC         = 8'h00;

  typedef struct packed {
    logic [2:0] addr;
    pin_vec_t   wdata;
    logic       wr;
    logic       rd;
  } reg_req_s;

  typedef struct packed {
    pin_vec_t o;
    pin_vec_t oe;
  } pad_drive_s;

endpackage

// ==== verif/bidirectional_port_pin_control_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, x); end end
module bidirectional_port_pin_control_tb;
  import gpio_port_pkg::*;
  logic       sys_clk = 1'b0;
  logic       rst_n   = 1'b0;
  reg_req_s   reg_req = '0;
  logic [7:0] reg_rdata;
  pin_vec_t   pad_in, pad_ibuf_en, digital_in, e, r;
  pin_vec_t   cfg_own = '0, analog_out_en = '0, ext_o = '0, ext_oe = '0;
  pad_drive_s pad_drive, cfg_drive = '0, alt_drive = '0;
  pin_vec_t   exp_q[$];
  pin_vec_t   rst_tab[8] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};
  logic       rd_q = 1'b0;
  int         n_fail = 0, cmp_count = 0, cyc = 0;

  bidirectional_port_pin_control bidirectional_port_pin_control_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .pad_in(pad_in), .pad_drive(pad_drive), .pad_ibuf_en(pad_ibuf_en),
    .digital_in(digital_in), .cfg_own(cfg_own), .cfg_drive(cfg_drive),
    .analog_out_en(analog_out_en), .alt_drive(alt_drive));
  pad_board_model pad_board_model_inst (
    .pad_drive(pad_drive), .ext_o(ext_o), .ext_oe(ext_oe), .pad_in(pad_in));

  always #12.5 sys_clk = ~sys_clk;

  function automatic pin_vec_t lfsr(input pin_vec_t s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic wr(input logic [2:0] a, input pin_vec_t d);
    @(posedge sys_clk);
    reg_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input pin_vec_t x);
    exp_q.push_back(x);
    @(posedge sys_clk);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so sample them there.
  always @(posedge sys_clk) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
    rd_q <= reg_req.rd;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) rd(i[2:0], rst_tab[i]);
    `CHK(pad_drive, 16'h0000)
    $display("test reset done");
    r = lfsr(8'h3f);
    wr(3'h3, 8'h00);
    wr(3'h1, 8'h00);
    wr(3'h2, r);
    repeat (4) @(posedge sys_clk);
    `CHK(pad_drive, {r, 8'hff})
    rd(3'h0, r);
    r = lfsr(r);
    wr(3'h0, r);
    rd(3'h2, r);
    wr(3'h3, 8'hff);
    repeat (4) @(posedge sys_clk);
    `CHK(pad_drive, {r, 8'hff})
    `CHK(digital_in, 8'h00)
    rd(3'h0, 8'h00);
    wr(3'h1, 8'hff);
    repeat (3) @(posedge sys_clk);
    `CHK(pad_drive.oe, 8'h00)
    $display("test latch and analog done");
    wr(3'h1, 8'h00);
    wr(3'h4, 8'hff);
    repeat (3) @(posedge sys_clk);
    `CHK(pad_drive.oe, ~r)
    alt_drive <= {8'h3c, 8'hff};
    wr(3'h4, 8'h00);
    wr(3'h5, 8'hff);
    wr(3'h6, 8'hf0);
    repeat (3) @(posedge sys_clk);
    `CHK(pad_drive, {8'h3c, 8'hcf})
    analog_out_en <= 8'hff;
    repeat (3) @(posedge sys_clk);
    `CHK(pad_drive.oe, 8'h00)
    `CHK(pad_ibuf_en, 8'h00)
    cfg_own <= 8'hff;
    cfg_drive <= {8'h5a, 8'hff};
    repeat (3) @(posedge sys_clk);
    `CHK(pad_drive, {8'h5a, 8'hff})
    `CHK(pad_ibuf_en, 8'hff)
    $display("test priority done");
    cfg_own <= 8'h00;
    analog_out_en <= 8'h00;
    r = lfsr(r);
    ext_o <= r;
    ext_oe <= 8'hff;
    wr(3'h5, 8'h00);
    wr(3'h1, 8'hff);
    wr(3'h3, 8'h00);
    repeat (4) @(posedge sys_clk);
    rd(3'h0, r);
    repeat (3) @(posedge sys_clk);
    $display("test input done");
    complete_run();
  end
endmodule

// ==== verif/pad_board_model.sv ====
`timescale 1ns/1ps
module pad_board_model (
  input  wire gpio_port_pkg::pad_drive_s pad_drive, // Drive from the port.
  input  wire gpio_port_pkg::pin_vec_t   ext_o,     // Board driver value.
  input  wire gpio_port_pkg::pin_vec_t   ext_oe,    // Board driver enable.
  output gpio_port_pkg::pin_vec_t        pad_in     // Resolved pin levels.
);
  import gpio_port_pkg::*;
  // Each pin has a board pull-up, so a released open-drain line reads high.
  assign pad_in = (pad_drive.oe & pad_drive.o) | (~pad_drive.oe & (~ext_oe | ext_o));
endmodule
